// >>> rtl/chip_select_pkg.sv
/*
 * Constants for the chip-select and wait-state unit: configuration
 * register addresses, reset values, field positions, timing counts,
 * the bus cycle state type and the I/O wait code table.
 * Assumes a 20 MHz clock; the timing counts are derived from it.
 */
package chip_select_pkg;

   // Register file geometry
   localparam int          CFG_COUNT   = 5;        // Configuration words
   localparam int          IDX_UPPER   = 0;        // Upper memory select
   localparam int          IDX_LOWER   = 1;        // Lower memory select
   localparam int          IDX_PBASE   = 2;        // Peripheral base select
   localparam int          IDX_MID     = 3;        // Midrange memory select
   localparam int          IDX_MODE    = 4;        // Peripheral select mode

   // I/O addresses of the configuration words
   localparam logic [15:0] CFG_ADDR [CFG_COUNT] = '{
      16'hFFA0, 16'hFFA2, 16'hFFA4, 16'hFFA6, 16'hFFA8};

   // Reset values match the start-up configuration
   localparam logic [15:0] CFG_RST [CFG_COUNT] = '{
      16'h80BF, 16'h7FBF, 16'h007F, 16'h81FF, 16'hA0BF};

   // Memory select fields (upper, lower, midrange share these)
   localparam int          MWAIT_MSB   = 1;        // Wait states 0..3
   localparam int          MWAIT_LSB   = 0;
   localparam int          MRDY_IGN    = 2;        // Ignore external ready
   localparam int          PSEUDO_STATIC_RAM_REFRESH_BIT   = 6;        // Lower: refresh enable
   localparam int          NIB_MSB     = 15;       // Upper base / lower top
   localparam int          NIB_LSB     = 12;       // Address bits 19..16
   localparam logic [3:0]  LOWER_TOP_MAX = 4'h7;   // Lower window cap 512K

   // Midrange select fields
   localparam int          MID_MSB     = 15;       // Base, address 19..13
   localparam int          MID_LSB     = 9;

   // Peripheral base fields
   localparam int          PBASE_MSB   = 15;       // Base, I/O address 15..8
   localparam int          PBASE_LSB   = 8;
   localparam int          PWAIT_MSB   = 2;        // I/O wait code
   localparam int          PWAIT_LSB   = 0;
   localparam int          PRDY_IGN    = 3;        // Ignore external ready

   // Peripheral mode fields
   localparam int          SIZE_MSB    = 14;       // One-hot block size
   localparam int          SIZE_LSB    = 8;        // Unit of 8K
   localparam int          CS_MODE_BIT = 7;        // Selects five and six are outputs

   // Peripheral selects
   localparam int          PER_COUNT   = 7;        // Selects zero to six
   localparam int          PER_LOW_LAST = 3;       // Last of the low group
   localparam int          PER_GATED   = 5;        // First gated by mode bit

   // Timing
   localparam int          CLK_PERIOD_NS  = 50;    // 20 MHz
   localparam int          STROBE_BASE_NS = 100;   // Strobe, no wait state
   localparam int          WAIT_STATE_NS  = 25;    // Added per wait state
   localparam int          BASE_CYC = (STROBE_BASE_NS + CLK_PERIOD_NS - 1)
                                      / CLK_PERIOD_NS;
   localparam int          WAIT_RAW = (WAIT_STATE_NS + CLK_PERIOD_NS - 1)
                                      / CLK_PERIOD_NS;
   localparam int          WAIT_CYC = (WAIT_RAW < 1) ? 1 : WAIT_RAW;
   localparam int          CNT_W    = 5;           // Holds 2 + 15

   // Bus cycle sequencer, Gray along the path through ST_READY
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,                           // Waiting for a cycle
      ST_STROBE = 2'b01,                           // Strobe and wait states
      ST_READY  = 2'b11,                           // Waiting for ready
      ST_FINISH = 2'b10                            // Cycle end, answer out
   } cycle_state_t;

   // I/O wait code to inserted wait states
   function automatic logic [3:0] io_wait_states(input logic [2:0] code);
      logic [3:0] w;
      w = 4'h0;
      unique case (code)
         3'h0: w = 4'h0;
         3'h1: w = 4'h1;
         3'h2: w = 4'h2;
         3'h3: w = 4'h3;
         3'h4: w = 4'h5;
         3'h5: w = 4'h7;
         3'h6: w = 4'h9;
         3'h7: w = 4'hF;
      endcase
      return w;
   endfunction

endpackage

// >>> rtl/wait_state_timer.sv
/*
 * Down counter that times the enable strobe of one bus cycle.
 * Assumes the loaded count is at least one and that a new load only
 * arrives once the previous count has run out.
 */
`timescale 1ns/1ns
module wait_state_timer
   import chip_select_pkg::*;
(
   input  wire logic             clock,      // 20 MHz clock
   input  wire logic             rst_b,      // Async reset, active low
   input  wire logic             load,       // Start counting, one pulse
   input  wire logic [CNT_W-1:0] loadCount,  // Strobe length in cycles
   output wire logic             running,    // Count in progress
   output wire logic             lastCycle   // Final strobe cycle
);

   logic [CNT_W-1:0] count_ff;               // Cycles still to run
   logic [CNT_W-1:0] nxt_count;              // Next count

   // Load on start, otherwise count down to zero
   assign nxt_count = load            ? loadCount :
                      (count_ff != '0) ? CNT_W'(count_ff - 1'b1) :
                                         count_ff;

   assign running   = (count_ff != '0);
   assign lastCycle = (count_ff == CNT_W'(1));

   // Counter register
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         count_ff <= '0;
      end else begin
         count_ff <= nxt_count;
      end
   end

endmodule

// >>> rtl/chip_select_unit.sv
/*
 * Chip-select and wait-state unit: decodes memory and I/O cycles of
 * the CPU bus into select lines, holds its configuration words in I/O
 * space, and stretches each cycle by the programmed wait states.
 * Assumes the CPU presents one cycle at a time with a start pulse and
 * holds nothing after it; all inputs are synchronous to the clock.
 */
`timescale 1ns/1ns
module chip_select_unit
   import chip_select_pkg::*;
(
   input  wire logic                 clock,          // 20 MHz clock
   input  wire logic                 rst_b,          // Async reset, low
   input  wire logic                 busStart,       // Cycle request pulse
   input  wire logic                 busIoSpace,     // 1 I/O, 0 memory
   input  wire logic                 busWrite,       // 1 write, 0 read
   input  wire logic                 busWide,        // 1 word, 0 byte
   input  wire logic [15:0]          busSegment,     // Memory segment
   input  wire logic [15:0]          busOffset,      // Offset / I/O addr
   input  wire logic [15:0]          busWrData,      // Write data
   input  wire logic [15:0]          extRdData,      // Data from devices
   input  wire logic                 extReady,       // External ready
   output logic                      romSelect,      // Upper memory
   output logic                      sramSelect,     // Lower memory
   output logic                      midrangeSelectZero, // Midrange
   output logic [PER_COUNT-1:0]      peripheralSelect,   // I/O selects
   output logic                      enableStrobe,   // Access enable
   output logic                      busDone,        // Cycle end pulse
   output logic [15:0]               rdData,         // Read answer
   output logic                      rdValid,        // Read data valid
   output logic                      busBusy,        // Cycle in progress
   output logic                      pseudoStaticRamRefresh // Refresh on
);

   // Configuration words and cycle state
   logic [15:0]          cfgRegs_ff [CFG_COUNT];  // Configuration words
   cycle_state_t         state_ff;                // Sequencer state
   cycle_state_t         nxt_state;               // Next state
   logic                 romSel_ff;               // Select registers
   logic                 sramSel_ff;
   logic                 midSel_ff;
   logic [PER_COUNT-1:0] perSel_ff;
   logic                 strobe_ff;               // Enable strobe
   logic                 done_ff;                 // Cycle end pulse
   logic [15:0]          rdData_ff;               // Read answer
   logic                 rdValid_ff;              // Answer valid
   logic                 needReady_ff;            // Wait for ready
   logic                 isRead_ff;               // Latched direction
   logic                 wide_ff;                 // Latched width
   logic                 lane_ff;                 // Latched byte lane
   logic                 mapped_ff;               // Some owner decoded
   logic [CFG_COUNT-1:0] regHit_ff;               // Own word addressed
   logic                 busy_ff;                 // Cycle in progress

   // Address formation
   logic [19:0]          physAddr;                // Memory address
   logic [15:0]          ioAddr;                  // I/O address
   logic                 accept;                  // Start taken
   logic                 isMem;                   // Memory cycle
   logic                 isIo;                    // I/O cycle

   assign physAddr = 20'({busSegment, 4'h0} + {4'h0, busOffset});
   assign ioAddr   = busOffset;
   assign isIo     = busIoSpace;
   assign isMem    = !busIoSpace;
   assign accept   = busStart && (state_ff == ST_IDLE);

   // Own configuration word decode, word aligned
   logic [CFG_COUNT-1:0] regHit;                  // Word addressed now
   logic                 regAny;                  // Any own word

   // Fields of the configuration words
   logic [15:0]          upperCfg;
   logic [15:0]          lowerCfg;
   logic [15:0]          pbaseCfg;
   logic [15:0]          midCfg;
   logic [15:0]          modeCfg;

   assign upperCfg = cfgRegs_ff[IDX_UPPER];
   assign lowerCfg = cfgRegs_ff[IDX_LOWER];
   assign pbaseCfg = cfgRegs_ff[IDX_PBASE];
   assign midCfg   = cfgRegs_ff[IDX_MID];
   assign modeCfg  = cfgRegs_ff[IDX_MODE];

   // Memory window decode
   logic [3:0]           lowerTop;                // Top nibble, capped
   logic [19:0]          midBase;                 // Midrange base
   logic [19:0]          midSize;                 // Midrange block bytes
   logic [19:0]          midLowMask;              // Offset bits in block
   logic                 upperHit;
   logic                 lowerHit;
   logic                 midHit;

   // Upper runs from its base to the top; 0x8 gives 512K
   assign upperHit = isMem &&
                     (physAddr[19:16] >= upperCfg[NIB_MSB:NIB_LSB]);
   // Lower starts at zero and never exceeds 512K
   assign lowerTop = (lowerCfg[NIB_MSB:NIB_LSB] > LOWER_TOP_MAX) ?
                     LOWER_TOP_MAX : lowerCfg[NIB_MSB:NIB_LSB];
   assign lowerHit = isMem && (physAddr[19:16] <= lowerTop);
   // Midrange block, one-hot size in 8K units; default 256K
   assign midBase    = {midCfg[MID_MSB:MID_LSB], 13'h0000};
   assign midSize    = {modeCfg[SIZE_MSB:SIZE_LSB], 13'h0000};
   assign midLowMask = 20'(midSize - 20'h00001);
   assign midHit     = isMem && (midSize != 20'h00000) &&
                       ((physAddr & ~midLowMask) ==
                        (midBase & ~midLowMask));

   // Peripheral decode, one 256-byte page per select
   logic [PER_COUNT-1:0] perHit;
   logic [7:0]           perBase;

   assign perBase = pbaseCfg[PBASE_MSB:PBASE_LSB];

   genvar n;
   generate
      for (n = 0; n < PER_COUNT; n++) begin : g_per
         // Page base plus one page per select
         logic pageHit;
         logic enabled;
         assign pageHit = (ioAddr[15:8] == 8'(perBase + 8'(n)));
         // Selects five and six act as chip selects only in select mode
         assign enabled = (n < PER_GATED) ? 1'b1 : modeCfg[CS_MODE_BIT];
         assign perHit[n] = isIo && !regAny && pageHit && enabled;
      end
      for (n = 0; n < CFG_COUNT; n++) begin : g_hit
         assign regHit[n] = isIo && (ioAddr[15:1] == CFG_ADDR[n][15:1]);
      end
   endgenerate

   assign regAny = |regHit;

   // Wait states of each owner
   logic [3:0]           upperWait;
   logic [3:0]           lowerWait;
   logic [3:0]           modeWait;
   logic [3:0]           perLowWait;
   logic [3:0]           memWait;
   logic [3:0]           ioWait;
   logic [3:0]           cycleWait;
   logic                 perLowAny;
   logic                 perHighAny;
   logic                 readyNeeded;

   // Memory selects insert 0..3 directly; default 3
   assign upperWait  = {2'b00, upperCfg[MWAIT_MSB:MWAIT_LSB]};
   assign lowerWait  = {2'b00, lowerCfg[MWAIT_MSB:MWAIT_LSB]};
   assign modeWait   = {2'b00, modeCfg[MWAIT_MSB:MWAIT_LSB]};
   // Low peripheral selects take the coded table; default 15
   assign perLowWait = io_wait_states(pbaseCfg[PWAIT_MSB:PWAIT_LSB]);
   assign perLowAny  = |perHit[PER_LOW_LAST:0];
   assign perHighAny = |perHit[PER_COUNT-1:PER_LOW_LAST+1];

   // Overlapping memory windows take the slowest owner
   always_comb begin
      memWait = 4'h0;
      if (upperHit && upperWait > memWait) begin
         memWait = upperWait;
      end
      if (lowerHit && lowerWait > memWait) begin
         memWait = lowerWait;
      end
      if (midHit && modeWait > memWait) begin
         memWait = modeWait;
      end
   end

   assign ioWait = perLowAny  ? perLowWait :
                   perHighAny ? modeWait   : 4'h0;
   assign cycleWait = isMem ? memWait : ioWait;

   // External ready is awaited unless every owner ignores it
   assign readyNeeded =
      (upperHit   && !upperCfg[MRDY_IGN]) ||
      (lowerHit   && !lowerCfg[MRDY_IGN]) ||
      (midHit     && !midCfg[MRDY_IGN])   ||
      (perLowAny  && !pbaseCfg[PRDY_IGN]) ||
      (perHighAny && !modeCfg[MRDY_IGN]);

   // Strobe length: base plus one step per wait state
   logic [CNT_W-1:0]     strobeCycles;
   logic                 timerLast;

   assign strobeCycles = CNT_W'(BASE_CYC + int'(cycleWait) * WAIT_CYC);

   wait_state_timer u_timer (
      .clock     (clock),
      .rst_b     (rst_b),
      .load      (accept),
      .loadCount (strobeCycles),
      .running   (),
      .lastCycle (timerLast)
   );

   // Sequencer transitions
   logic                 endCycle;                // Leaving for FINISH

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_IDLE: begin
            if (accept) begin
               nxt_state = ST_STROBE;
            end
         end
         ST_STROBE: begin
            if (timerLast) begin
               nxt_state = (needReady_ff && !extReady) ?
                           ST_READY : ST_FINISH;
            end
         end
         ST_READY: begin
            if (extReady) begin
               nxt_state = ST_FINISH;
            end
         end
         ST_FINISH: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   assign endCycle = (state_ff != ST_FINISH) && (nxt_state == ST_FINISH);

   // Configuration write data with byte lanes
   logic                 regWrite;
   logic [15:0]          wrMerged [CFG_COUNT];

   assign regWrite = accept && busWrite;

   generate
      for (n = 0; n < CFG_COUNT; n++) begin : g_cfg
         // Word writes replace all; byte writes go to the addressed lane
         assign wrMerged[n] = busWide    ? busWrData :
                              ioAddr[0]  ? {busWrData[7:0],
                                            cfgRegs_ff[n][7:0]} :
                                           {cfgRegs_ff[n][15:8],
                                            busWrData[7:0]};
         // Reset to start-up values
         always_ff @(posedge clock or negedge rst_b) begin
            if (!rst_b) begin
               cfgRegs_ff[n] <= CFG_RST[n];
            end else if (regWrite && regHit[n]) begin
               cfgRegs_ff[n] <= wrMerged[n];
            end
         end
      end
   endgenerate

   // Read answer selection
   logic [15:0]          regWord;                 // Addressed own word
   logic [15:0]          srcWord;                 // Own or device word
   logic [15:0]          answer;                  // Lane-adjusted

   always_comb begin
      regWord = 16'h0000;
      for (int i = 0; i < CFG_COUNT; i++) begin
         if (regHit_ff[i]) begin
            regWord = regWord | cfgRegs_ff[i];
         end
      end
   end

   assign srcWord = (|regHit_ff) ? regWord : extRdData;
   assign answer  = wide_ff ? srcWord :
                    lane_ff ? {8'h00, srcWord[15:8]} :
                              {8'h00, srcWord[7:0]};

   // Sequencer state and latched cycle attributes
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state_ff     <= ST_IDLE;
         needReady_ff <= 1'b0;
         isRead_ff    <= 1'b0;
         wide_ff      <= 1'b0;
         lane_ff      <= 1'b0;
         mapped_ff    <= 1'b0;
         regHit_ff    <= '0;
         busy_ff      <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         busy_ff  <= (nxt_state != ST_IDLE);
         if (accept) begin
            needReady_ff <= readyNeeded;
            isRead_ff    <= !busWrite;
            wide_ff      <= busWide;
            lane_ff      <= busOffset[0];
            mapped_ff    <= upperHit || lowerHit || midHit ||
                            (|perHit) || regAny;
            regHit_ff    <= regHit;
         end
      end
   end

   // Selects rise with the cycle and fall as it ends
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         romSel_ff  <= 1'b0;
         sramSel_ff <= 1'b0;
         midSel_ff  <= 1'b0;
         perSel_ff  <= '0;
      end else if (accept) begin
         romSel_ff  <= upperHit;
         sramSel_ff <= lowerHit;
         midSel_ff  <= midHit;
         perSel_ff  <= perHit;
      end else if (endCycle) begin
         romSel_ff  <= 1'b0;
         sramSel_ff <= 1'b0;
         midSel_ff  <= 1'b0;
         perSel_ff  <= '0;
      end
   end

   // Enable strobe spans base time plus wait states
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         strobe_ff <= 1'b0;
      end else if (accept) begin
         strobe_ff <= 1'b1;
      end else if (timerLast) begin
         strobe_ff <= 1'b0;
      end
   end

   // Cycle end pulse and read answer; unmapped reads are not valid
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         done_ff    <= 1'b0;
         rdData_ff  <= 16'h0000;
         rdValid_ff <= 1'b0;
      end else begin
         done_ff <= endCycle;
         if (endCycle && isRead_ff) begin
            rdData_ff  <= answer;
            rdValid_ff <= mapped_ff;
         end else if (accept) begin
            rdValid_ff <= 1'b0;
         end
      end
   end

   // Outputs straight from flip-flops
   assign romSelect              = romSel_ff;
   assign sramSelect             = sramSel_ff;
   assign midrangeSelectZero     = midSel_ff;
   assign peripheralSelect       = perSel_ff;
   assign enableStrobe           = strobe_ff;
   assign busDone                = done_ff;
   assign rdData                 = rdData_ff;
   assign rdValid                = rdValid_ff;
   assign busBusy                = busy_ff;
   // Refresh follows its bit of the lower word; off by default
   assign pseudoStaticRamRefresh = cfgRegs_ff[IDX_LOWER][PSEUDO_STATIC_RAM_REFRESH_BIT];

endmodule

// >>> tb/chip_select_unit_monitor.sv
/* Port-timing checker bound to each select unit.
   Assumes one clock domain and the active-low asynchronous reset. */
`timescale 1ns/1ns
module chip_select_unit_monitor
   import chip_select_pkg::*;
(
   input wire logic                 clock,              // Clock
   input wire logic                 rst_b,              // Reset, low
   input wire logic                 busStart,           // Cycle request
   input wire logic                 romSelect,          // Upper select
   input wire logic                 sramSelect,         // Lower select
   input wire logic                 midrangeSelectZero, // Midrange
   input wire logic [PER_COUNT-1:0] peripheralSelect,   // I/O selects
   input wire logic                 enableStrobe,       // Enable strobe
   input wire logic                 busDone,            // Cycle end
   input wire logic                 rdValid,            // Read valid
   input wire logic                 busBusy             // Busy
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   // Any select line raised
   wire anySel = romSelect | sramSelect | midrangeSelectZero
                 | (|peripheralSelect);
   start_taken_a: assert property (
      busStart && !busBusy |=> busBusy && enableStrobe)
      else $error("start not taken");
   strobe_min_a: assert property (
      $rose(enableStrobe) |=> enableStrobe)
      else $error("strobe too short");
   strobe_cause_a: assert property (
      $rose(enableStrobe) |-> $past(busStart))
      else $error("strobe without start");
   strobe_bound_a: assert property (
      $rose(enableStrobe) |-> ##[1:17] !enableStrobe)
      else $error("strobe too long");
   done_pulse_a: assert property (busDone |=> !busDone && !busBusy)
      else $error("done not a single pulse");
   done_clear_a: assert property (
      busDone |-> !anySel && !enableStrobe)
      else $error("selects held past cycle end");
   sel_busy_a: assert property (anySel |-> busBusy)
      else $error("select outside a cycle");
   sel_steady_a: assert property (
      anySel && !busDone |=> anySel || busDone)
      else $error("select dropped early");
   valid_done_a: assert property ($rose(rdValid) |-> busDone)
      else $error("valid without cycle end");
   cover property (busDone && rdValid && romSelect == 1'b0);
   cover property (|peripheralSelect);
   cover property (busDone && !rdValid);
endmodule
bind chip_select_unit chip_select_unit_monitor mon (.clock, .rst_b,
   .busStart, .romSelect, .sramSelect, .midrangeSelectZero,
   .peripheralSelect, .enableStrobe, .busDone, .rdValid, .busBusy);

// >>> tb/bus_device_model.sv
/* ROM, SRAM and peripherals answering on the far side of the selects.
   Assumes selects are active high; an unselected bus keeps changing. */
`timescale 1ns/1ns
module bus_device_model (
   input  wire logic       clock,              // Clock
   input  wire logic       slow,               // Late ready from SRAM
   input  wire logic       romSelect,          // Upper select
   input  wire logic       sramSelect,         // Lower select
   input  wire logic [6:0] peripheralSelect,   // I/O selects
   output logic [15:0]     extRdData,          // Read data
   output logic            extReady            // Ready
);
   logic [15:0] floatBus_ff = 16'h5A5A; // Undriven bus value
   logic [1:0]  lagCnt_ff   = 2'h0; // Ready delay count
   // Floating bus drifts, SRAM ready counts while selected
   always_ff @(posedge clock) begin
      floatBus_ff <= ~floatBus_ff + 16'h0001;
      lagCnt_ff   <= sramSelect ? lagCnt_ff + 2'h1 : 2'h0;
   end
   assign extReady  = !slow || lagCnt_ff == 2'h3;
   // Each device returns its own pattern, an unselected bus returns the drifting value
   assign extRdData = romSelect ? 16'hC3A5 : sramSelect ? 16'h5AB1 :
                      |peripheralSelect ? {9'h000, peripheralSelect} :
                      floatBus_ff;
endmodule

// >>> tb/tb_chip_select_unit.sv
/* Self-checking bench: config words, windows, waits, random cycles.
   Assumes the device model and the bound checker beside the unit. */
`timescale 1ns/1ns
module tb_chip_select_unit import chip_select_pkg::*;;
   logic        clock = 1'b0, rst_b = 1'b0, busStart = 1'b0, slow = 1'b0;
   logic        busIoSpace = 1'b0, busWrite = 1'b0, busWide = 1'b1;
   logic [15:0] busSegment = 16'h0000, busOffset = 16'h0000;
   logic [15:0] busWrData = 16'h0000, extRdData, rdData, o;
   logic        extReady, romSelect, sramSelect, midrangeSelectZero;
   logic        enableStrobe, busDone, rdValid, busBusy;
   logic        pseudoStaticRamRefresh;
   logic [6:0]  peripheralSelect;
   logic [15:0] selSeen;  // Selects seen in cycle 1
   logic [15:0] cfgVal [5] = '{16'h80BF, 16'h7FBF, 16'h007F, 16'h81FF,
                               16'hA0BF};       // Start-up words
   int          n_mismatch = 0, total_checks = 0, cyc = 0, nStb, t0;
   int          seed = 52058;
   chip_select_unit dut (.clock, .rst_b, .busStart, .busIoSpace,
      .busWrite, .busWide, .busSegment, .busOffset, .busWrData,
      .extRdData, .extReady, .romSelect, .sramSelect,
      .midrangeSelectZero, .peripheralSelect, .enableStrobe, .busDone,
      .rdData, .rdValid, .busBusy, .pseudoStaticRamRefresh);
   bus_device_model dev (.clock, .slow, .romSelect, .sramSelect,
      .peripheralSelect, .extRdData, .extReady);
   // Clock and cycle ceiling
   initial forever #25 clock = ~clock;
   always @(posedge clock) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         tally_and_finish;
      end
   end
   // Compare and count
   task automatic chk(input string nm, input logic [15:0] e, g);
      total_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One bus cycle; counts strobe cycles and records the selects
   task automatic bus(input logic io, wr, wide, input logic [15:0] s, f, d);
      @(posedge clock);
      busStart   <= 1'b1;
      busIoSpace <= io;
      busWrite   <= wr;
      busWide    <= wide;
      busSegment <= s;
      busOffset  <= f;
      busWrData  <= d;
      @(posedge clock);
      busStart <= 1'b0;
      nStb = 0;
      for (int k = 0; k < 60 && busDone !== 1'b1; k++) begin
         @(negedge clock);
         nStb += (enableStrobe === 1'b1);
         if (k == 0) begin
            selSeen = {6'h00, romSelect, sramSelect, midrangeSelectZero,
                       peripheralSelect};
         end
      end
      chk("done", 16'h0001, {15'h0000, busDone});
   endtask
   // Strobe length for an I/O wait code
   function automatic logic [15:0] strobeLen(input logic [2:0] c);
      logic [15:0] t [8] = '{16'h0, 16'h1, 16'h2, 16'h3, 16'h5, 16'h7,
                             16'h9, 16'hF};
      return 16'h0002 + t[c];
   endfunction
   // Verdict
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clock);
      rst_b <= 1'b1;
      // Reset words, then the start-up writes
      for (int i = 0; i < 5; i++) begin
         o = 16'hFFA0 + 16'(2 * i);
         bus(1'b1, 1'b0, 1'b1, 16'h0000, o, 16'h0000);
         chk("cfg word", cfgVal[i], rdData);
         bus(1'b1, 1'b1, 1'b1, 16'h0000, o,
             cfgVal[i]);
      end
      chk("refresh", 16'h0000, {15'h0000, pseudoStaticRamRefresh});
      // Top of lower window and bottom of upper window
      bus(1'b0, 1'b0, 1'b1, 16'h7FFF, 16'h0010, 16'h0000);
      chk("upper sel", 16'h0280, selSeen);
      chk("rom strobe", 16'h0005, 16'(nStb));
      chk("rom data", 16'hC3A5, rdData);
      bus(1'b0, 1'b0, 1'b0, 16'h7FFF, 16'h000F, 16'h0000);
      chk("sram byte", 16'h005A, rdData);
      chk("sram sel", 16'h0100, selSeen);
      // Random SRAM words
      for (int i = 0; i < 8; i++) begin
         bus(1'b0, 1'b0, 1'b1, 16'($random(seed) & 16'h6FFF),
             16'($random(seed)), 16'h0000);
         chk("sram sel", 16'h0100, selSeen);
         chk("sram strobe", 16'h0005, 16'(nStb));
         chk("sram data", 16'h5AB1, rdData);
      end
      // Peripheral pages zero to six
      for (int k = 0; k < 7; k++) begin
         o = 16'(k * 256) | (16'($random(seed)) & 16'h00FF);
         bus(1'b1, 1'b0, 1'b1, 16'h0000, o, 16'h0000);
         chk("per sel", 16'(1 << k), selSeen);
         chk("per strobe", k < 4 ? 16'h0011 : 16'h0005,
             16'(nStb));
         chk("per valid", 16'h0001, {15'h0000, rdValid});
      end
      // Every I/O wait code
      for (int c = 0; c < 8; c++) begin
         bus(1'b1, 1'b1, 1'b1, 16'h0000, 16'hFFA4, 16'h0078 | 16'(c));
         bus(1'b1, 1'b0, 1'b1, 16'h0000, 16'h0200, 16'h0000);
         chk("io strobe", strobeLen(3'(c)), 16'(nStb));
      end
      // Unmapped I/O read
      bus(1'b1, 1'b0, 1'b1, 16'h0000, 16'h9000, 16'h0000);
      chk("unmapped", 16'h0000, {selSeen[14:0], rdValid});
      // Refresh on, SRAM waits for a late ready
      bus(1'b1, 1'b1, 1'b1, 16'h0000, 16'hFFA2, 16'h7FFB);
      chk("refresh", 16'h0001, {15'h0000, pseudoStaticRamRefresh});
      slow <= 1'b1;
      t0 = cyc;
      bus(1'b0, 1'b0, 1'b1, 16'h0000, 16'h0100, 16'h0000);
      chk("late ready", 16'h0001, {15'h0000, rdValid});
      chk("ready wait", 16'h000A, 16'(cyc - t0));
      tally_and_finish;
   end
endmodule
